// ---- verilog/smirq_top.v ----
// security module interrupt logic: cause flags, enables, rearm write,
// trigger style and serial slot output, with an apb register slave.
// assumes one clock and synchronous events pulsed one cycle each.
`timescale 1ns/1ps
`default_nettype none
`include "smirq_map.vh"

module smirq_top (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SMIRQ_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // cause events, one-cycle pulses
    input wire ev_owner_switch,
    input wire ev_response_ready,
    input wire ev_status_valid,
    input wire ev_accept_next_cmd,
    // serial interrupt line as three signals
    input wire sirq_in,
    output reg sirq_out,
    output reg sirq_oe,
    // state views
    output reg irq_pending,
    output reg irq_line_active
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg master_irq_gate; // global gate
    reg [1:0] trigger_style; // line style
    reg en_owner, en_resp, en_stsval, en_accept; // per-cause enables
    reg owner_switch_flag, response_ready_flag; // mandatory causes
    reg status_valid_flag, accept_next_cmd_flag; // optional causes
    reg [`SMIRQ_VEC_W-1:0] vector; // selected irq slot
    reg [3:0] gate_quiet; // hold-off after a gate change

    // interrupt sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'b001; // armed, nothing sent
    localparam [2:0] ST_ACTIVE = 3'b010; // sent, waiting for rearm
    localparam [2:0] ST_QUIET = 3'b100; // gate settling
    reg [2:0] state;

    // pulse stretch for edge styles, counts frames' worth of clocks
    reg [7:0] pulse_cnt;
    reg line_assert; // logical assertion, before polarity

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire acc = psel && penable; // access phase
    wire wr = acc && pwrite;
    wire hit_en = paddr == `SMIRQ_OFF_ENABLE;
    wire hit_cf = paddr == `SMIRQ_OFF_CAUSE;
    wire hit_cap = paddr == `SMIRQ_OFF_CAP;
    wire hit_vec = paddr == `SMIRQ_OFF_VECTOR;
    wire hit_any = hit_en || hit_cf || hit_cap || hit_vec;
    wire rearm = wr && hit_cf; // irq_rearm_write
    wire en_write = wr && hit_en;
    wire gate_change = en_write && (pwdata[`SMIRQ_EN_GATE] != master_irq_gate);

    // packs the cause flags into register layout
    function [7:0] pack_flags;
        input a, o, s, r;
        begin
            pack_flags = `SMIRQ_CF_ZERO;
            pack_flags[`SMIRQ_CF_ACCEPT] = a;
            pack_flags[`SMIRQ_CF_OWNER] = o;
            pack_flags[`SMIRQ_CF_STSVAL] = s;
            pack_flags[`SMIRQ_CF_RESP] = r;
        end
    endfunction

    // one flag update: event wins over a clearing write
    function next_flag;
        input cur, ev, clr;
        begin
            next_flag = ev | (cur & ~clr);
        end
    endfunction

    wire [7:0] flags = pack_flags(accept_next_cmd_flag, owner_switch_flag,
                                  status_valid_flag, response_ready_flag);
    wire [7:0] clr = rearm ? (pwdata[7:0] & `SMIRQ_CF_MASK) : `SMIRQ_CF_ZERO;
    wire [7:0] ev = pack_flags(ev_accept_next_cmd, ev_owner_switch,
                               ev_status_valid, ev_response_ready);
    wire [7:0] nflags = (ev | (flags & ~clr)) & `SMIRQ_CF_MASK;
    wire [7:0] enables = pack_flags(en_accept, en_owner, en_stsval, en_resp);
    // enabled and gated causes after this cycle's updates
    wire any_cause = master_irq_gate && |(nflags & enables);

    // ----------------------------------------
    // cause flags
    // ----------------------------------------
    // shared by every locality, so there is one copy only
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            owner_switch_flag <= 1'b0;
            response_ready_flag <= 1'b0;
            status_valid_flag <= 1'b0;
            accept_next_cmd_flag <= 1'b0;
        end else begin
            owner_switch_flag <= next_flag(owner_switch_flag, ev_owner_switch,
                                           clr[`SMIRQ_CF_OWNER]);
            response_ready_flag <= next_flag(response_ready_flag,
                                             ev_response_ready, clr[`SMIRQ_CF_RESP]);
            status_valid_flag <= next_flag(status_valid_flag, ev_status_valid,
                                           clr[`SMIRQ_CF_STSVAL]);
            accept_next_cmd_flag <= next_flag(accept_next_cmd_flag,
                                              ev_accept_next_cmd, clr[`SMIRQ_CF_ACCEPT]);
        end
    end

    // ----------------------------------------
    // enable and vector registers
    // ----------------------------------------
    // one register set for all localities
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            master_irq_gate <= 1'b0;
            trigger_style <= `SMIRQ_STY_LOW;
            en_owner <= 1'b0;
            en_resp <= 1'b0;
            en_stsval <= 1'b0;
            en_accept <= 1'b0;
            vector <= `SMIRQ_VEC_RESET;
        end else begin
            if (en_write) begin
                master_irq_gate <= pwdata[`SMIRQ_EN_GATE];
                trigger_style <= pwdata[`SMIRQ_EN_STYLE_HI:`SMIRQ_EN_STYLE_LO];
                en_owner <= pwdata[`SMIRQ_EN_OWNER];
                en_resp <= pwdata[`SMIRQ_EN_RESP];
                en_stsval <= pwdata[`SMIRQ_EN_STSVAL];
                en_accept <= pwdata[`SMIRQ_EN_ACCEPT];
            end
            if (wr && hit_vec) begin
                vector <= pwdata[`SMIRQ_VEC_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // interrupt sequencer
    // ----------------------------------------
    // one assertion per rearm; gate changes force a quiet spell
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            gate_quiet <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (gate_change) begin
                        state <= ST_QUIET;
                        gate_quiet <= 4'hf;
                    end else if (any_cause) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (gate_change) begin
                        state <= ST_QUIET;
                        gate_quiet <= 4'hf;
                    end else if (rearm) begin
                        // besides a gate change, only a rearm leaves this state
                        state <= any_cause ? ST_ACTIVE : ST_IDLE;
                    end
                end
                ST_QUIET: begin
                    if (gate_change) begin
                        gate_quiet <= 4'hf;
                    end else if (gate_quiet == 4'h0) begin
                        state <= ST_IDLE;
                    end else begin
                        gate_quiet <= gate_quiet - 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // line assertion and trigger style
    // ----------------------------------------
    // levels hold while active; edge styles give a pulse, then rest.
    // a rearm that re-triggers drops the line for one clock first
    wire retrig = state == ST_ACTIVE && rearm && any_cause;
    wire start_assert = (state == ST_IDLE && !gate_change && any_cause) || retrig;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            line_assert <= 1'b0;
            pulse_cnt <= 8'h00;
        end else if (state != ST_ACTIVE && !start_assert) begin
            line_assert <= 1'b0;
            pulse_cnt <= 8'h00;
        end else if (start_assert) begin
            line_assert <= !retrig;
            pulse_cnt <= 8'hff;
        end else if (trigger_style == `SMIRQ_STY_RISE ||
                     trigger_style == `SMIRQ_STY_FALL) begin
            // edge style: pulse then return to rest
            line_assert <= pulse_cnt != 8'h00;
            if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end else begin
            // level style: hold until the rearm write
            line_assert <= 1'b1;
        end
    end

    // active low styles drive low when asserted, high styles when idle
    wire want_low = (trigger_style == `SMIRQ_STY_LOW ||
                     trigger_style == `SMIRQ_STY_FALL) ? line_assert : !line_assert;

    // ----------------------------------------
    // serial slot output
    // ----------------------------------------
    wire slot_out;
    wire slot_oe;
    smirq_slot u_slot (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .vector(vector),
        .drive_low(want_low),
        .sirq_in(sirq_in),
        .sirq_out(slot_out),
        .sirq_oe(slot_oe)
    );

    // register the pins and state views
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sirq_out <= 1'b1;
            sirq_oe <= 1'b0;
            irq_pending <= 1'b0;
            irq_line_active <= 1'b0;
        end else begin
            sirq_out <= slot_out;
            sirq_oe <= slot_oe;
            irq_pending <= |flags;
            irq_line_active <= line_assert;
        end
    end

    // ----------------------------------------
    // apb response
    // ----------------------------------------
    // zero wait states; unmapped address answers slverr, reads zero
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                if (hit_en) begin
                    prdata <= {master_irq_gate, 23'h000000, en_accept, 2'h0,
                               trigger_style, en_owner, en_stsval, en_resp};
                end else if (hit_cf) begin
                    prdata <= {24'h000000, flags};
                end else if (hit_cap) begin
                    prdata <= `SMIRQ_CAP_VALUE;
                end else if (hit_vec) begin
                    prdata <= {28'h0000000, vector};
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- include/smirq_map.vh ----
// constants for the security module interrupt logic: register offsets,
// field positions, reset values and serial interrupt frame timing.
// assumes an apb slave in front of the registers and a serial irq host.
`ifndef SMIRQ_MAP_VH
`define SMIRQ_MAP_VH

// register byte offsets
`define SMIRQ_OFF_ENABLE 12'h008
`define SMIRQ_OFF_CAUSE 12'h010
`define SMIRQ_OFF_CAP 12'h014
`define SMIRQ_OFF_VECTOR 12'h00c
`define SMIRQ_OFF_EVENT 12'h018
`define SMIRQ_ADDR_W 12

// enable register fields
`define SMIRQ_EN_GATE 31
`define SMIRQ_EN_ACCEPT 7
`define SMIRQ_EN_STYLE_HI 4
`define SMIRQ_EN_STYLE_LO 3
`define SMIRQ_EN_OWNER 2
`define SMIRQ_EN_STSVAL 1
`define SMIRQ_EN_RESP 0
`define SMIRQ_EN_MASK 32'h8000009f
`define SMIRQ_EN_RESET 32'h00000008

// cause register fields
`define SMIRQ_CF_ACCEPT 7
`define SMIRQ_CF_OWNER 2
`define SMIRQ_CF_STSVAL 1
`define SMIRQ_CF_RESP 0
`define SMIRQ_CF_MASK 8'h87
`define SMIRQ_CF_ZERO 8'h00

// capability: all four styles and three causes; bit 7, the accept cause position, is clear
`define SMIRQ_CAP_VALUE 32'h0000007f

// trigger style codes
`define SMIRQ_STY_HIGH 2'h0
`define SMIRQ_STY_LOW 2'h1
`define SMIRQ_STY_RISE 2'h2
`define SMIRQ_STY_FALL 2'h3

// vector field and reset
`define SMIRQ_VEC_W 4
`define SMIRQ_VEC_RESET 4'h0

// serial frame: start frame low, then 3 clocks per slot
`define SMIRQ_START_LEN 4'h6
`define SMIRQ_SLOT_CLKS 2'h3
`define SMIRQ_SLOT_W 5
`define SMIRQ_LAST_IRQ_SLOT 5'h0f

`endif

// ---- verilog/smirq_slot.v ----
// serial interrupt slot driver: follows host start frames and drives the
// line low in the sample phase of the selected irq slot only.
// assumes sirq_in is the resolved line level, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "smirq_map.vh"

module smirq_slot (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // slot selection and requested line level in the slot
    input wire [`SMIRQ_VEC_W-1:0] vector,
    input wire drive_low,
    // serial interrupt line
    input wire sirq_in,
    output reg sirq_out,
    output reg sirq_oe
);

    // ----------------------------------------
    // frame tracker
    // ----------------------------------------
    reg [3:0] low_run; // length of current low period
    reg prev_in; // line one clock ago
    reg in_frame; // counting slots
    reg [`SMIRQ_SLOT_W-1:0] slot; // current slot number
    reg [1:0] phase; // clock within the slot

    wire start_end = in_frame == 1'b0 && prev_in == 1'b0 && sirq_in == 1'b1 &&
                     low_run >= `SMIRQ_START_LEN;
    wire our_slot = in_frame && slot == {1'b0, vector};

    // count start frame, then walk slots; stop after irq slot 15
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            low_run <= 4'h0;
            prev_in <= 1'b1;
            in_frame <= 1'b0;
            slot <= 5'h00;
            phase <= 2'h0;
        end else begin
            prev_in <= sirq_in;
            if (sirq_in == 1'b0 && low_run != 4'hf) begin
                low_run <= low_run + 4'h1;
            end else if (sirq_in == 1'b1) begin
                low_run <= 4'h0;
            end
            if (start_end) begin
                // first turnaround clock is phase one of no slot
                in_frame <= 1'b1;
                // all ones wraps to irq slot zero once the turnaround ends
                slot <= 5'h1f;
                phase <= 2'h1;
            end else if (in_frame) begin
                if (phase == `SMIRQ_SLOT_CLKS - 2'h1) begin
                    phase <= 2'h0;
                    if (slot == `SMIRQ_LAST_IRQ_SLOT) begin
                        // stop before pci slots a to d
                        in_frame <= 1'b0;
                    end else begin
                        slot <= slot + 5'h01;
                    end
                end else begin
                    phase <= phase + 2'h1;
                end
            end
        end
    end

    // drive low in sample phase, high in recovery, float otherwise
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sirq_out <= 1'b1;
            sirq_oe <= 1'b0;
        end else if (our_slot && phase == 2'h0 && drive_low) begin
            sirq_out <= 1'b0;
            sirq_oe <= 1'b1;
        end else if (our_slot && phase == 2'h1 && sirq_oe) begin
            sirq_out <= 1'b1; // recovery clock
            sirq_oe <= 1'b1;
        end else begin
            sirq_out <= 1'b1;
            sirq_oe <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- bench/smirq_chk.sv ----
// checker for the security module interrupt logic ports
// assumes it is bound to smirq_top and shares its single clock
`timescale 1ns/1ps
`default_nettype none
`include "smirq_map.vh"

module smirq_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SMIRQ_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // events, serial line and state views
    input wire logic ev_owner_switch,
    input wire logic ev_response_ready,
    input wire logic ev_status_valid,
    input wire logic ev_accept_next_cmd,
    input wire logic sirq_in,
    input wire logic sirq_out,
    input wire logic sirq_oe,
    input wire logic irq_pending,
    input wire logic irq_line_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // helper logic: gate copy and rearm memory
    // ----------------------------------------
    logic gate_q, gate_d, act_q, rearm_q, once_q;
    wire acc = psel && penable && pready && pwrite;
    wire en_wr = acc && (paddr == `SMIRQ_OFF_ENABLE);
    wire cf_wr = acc && (paddr == `SMIRQ_OFF_CAUSE);
    wire rose = irq_line_active && !act_q;
    wire any_ev = ev_owner_switch || ev_response_ready || ev_status_valid || ev_accept_next_cmd;
    wire mapped = (paddr == `SMIRQ_OFF_ENABLE) || (paddr == `SMIRQ_OFF_CAUSE)
        || (paddr == `SMIRQ_OFF_CAP) || (paddr == `SMIRQ_OFF_VECTOR);
    // track gate and whether a rearm or a gate change came since the last assertion
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            gate_q <= 1'b0;
            gate_d <= 1'b0;
            act_q <= 1'b0;
            rearm_q <= 1'b0;
            once_q <= 1'b0;
        end else begin
            gate_q <= en_wr ? pwdata[`SMIRQ_EN_GATE] : gate_q;
            gate_d <= gate_q;
            act_q <= irq_line_active;
            rearm_q <= (cf_wr || (en_wr && pwdata[`SMIRQ_EN_GATE] != gate_q)) ? 1'b1 :
                (rose ? 1'b0 : rearm_q);
            once_q <= once_q || rose;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    unmapped_err_a: assert property (psel && penable && pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    event_latch_a: assert property (any_ev |-> ##2 irq_pending)
        else $error("event did not set a flag");
    rise_cause_a: assert property (rose |-> irq_pending)
        else $error("interrupt without a set flag");
    rearm_block_a: assert property (rose && once_q |-> rearm_q)
        else $error("second interrupt without rearm");
    gate_off_a: assert property (!gate_q && !gate_d |-> !irq_line_active)
        else $error("interrupt active with gate off");
    gate_change_a: assert property (en_wr && pwdata[31] != gate_q |-> ##1 !irq_line_active [*8])
        else $error("interrupt active during gate change");
    slot_recover_a: assert property (sirq_oe && !sirq_out |=> sirq_oe && sirq_out)
        else $error("no recovery after slot drive");
    slot_single_a: assert property (sirq_oe && sirq_out |=> !sirq_oe)
        else $error("line held past recovery");
endmodule
`default_nettype wire

// ---- bench/smirq_host.sv ----
// host side serial interrupt model: start frames, pull-up, slot capture
// assumes the device drives only through sirq_out and sirq_oe
`timescale 1ns/1ps
`default_nettype none

module smirq_host (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // device drive
    input wire logic sirq_out,
    input wire logic sirq_oe,
    // resolved line and slots seen low in the last frame
    output logic sirq_line,
    output logic [31:0] last_mask,
    output logic [15:0] frames
);
    localparam int START = 8;
    localparam int FRAME = 108;
    localparam int SLOT0 = START + 3; // turnaround before irq slot zero
    logic [7:0] cnt;
    logic [31:0] cur_mask;
    // pull-up line: host start frame or device low wins
    assign sirq_line = (cnt < START) ? 1'b0 : (!sirq_oe || sirq_out);
    // free running frames, three clocks per slot after the start frame
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            cur_mask <= 32'h0;
            last_mask <= 32'h0;
            frames <= 16'h0;
        end else begin
            cnt <= (cnt == FRAME - 1) ? 8'h00 : cnt + 8'h01;
            if (cnt == FRAME - 1) begin
                last_mask <= cur_mask;
                cur_mask <= 32'h0;
                frames <= frames + 16'h1;
            end else if (cnt >= SLOT0 && cnt < SLOT0 + 96 && !sirq_line) begin
                cur_mask[(cnt - SLOT0) / 3] <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking testbench for the security module interrupt logic
// assumes smirq_host as the serial host and smirq_chk bound below
`timescale 1ns/1ps
`default_nettype none
`include "smirq_map.vh"

module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] ev = 4'h0;
    logic [31:0] prdata, rdata, last_mask;
    logic pready, pslverr, rerr, sirq_line, sirq_out, sirq_oe, irq_pending, irq_line_active;
    logic [15:0] frames;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    always #4 clk_sys = ~clk_sys;
    smirq_top smirq_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ev_owner_switch(ev[2]), .ev_response_ready(ev[0]),
        .ev_status_valid(ev[1]), .ev_accept_next_cmd(ev[3]), .sirq_in(sirq_line),
        .sirq_out(sirq_out), .sirq_oe(sirq_oe), .irq_pending(irq_pending),
        .irq_line_active(irq_line_active));
    smirq_host smirq_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sirq_out(sirq_out),
        .sirq_oe(sirq_oe), .sirq_line(sirq_line), .last_mask(last_mask), .frames(frames));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no local limit: the bench's cycle ceiling ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk_sys);
        ev <= 4'h0;
        @(posedge clk_sys);
    endtask
    // wait, bounded, for the interrupt state to reach a level
    task automatic wait_act(input logic lvl);
        int n;
        n = 0;
        while (irq_line_active !== lvl && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
    endtask
    task automatic wait_frames();
        int n;
        logic [15:0] f;
        n = 0;
        f = frames;
        while (frames !== f + 16'h2 && n < 400) begin
            n++;
            @(posedge clk_sys);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, `SMIRQ_OFF_ENABLE, 32'h0);
        chk("enable reset", rdata, 32'h00000008);
        apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
        chk("cause reset", rdata, 32'h0);
        apb(1'b0, `SMIRQ_OFF_CAP, 32'h0);
        chk("capability", rdata, `SMIRQ_CAP_VALUE);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'hffffffff);
        apb(1'b0, `SMIRQ_OFF_ENABLE, 32'h0);
        chk("enable mask", rdata, 32'h8000009f);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `SMIRQ_OFF_ENABLE, s << 3);
            apb(1'b0, `SMIRQ_OFF_ENABLE, 32'h0);
            chk("style code", rdata, s << 3);
        end
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h00000008);
        $display("test regs done");
    endtask
    task automatic t_slots();
        logic [3:0] vec [3] = '{4'h0, 4'hf, 4'h6};
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h80000009);
        foreach (vec[k]) begin
            apb(1'b1, `SMIRQ_OFF_VECTOR, {28'h0, vec[k]});
            pulse(0);
            wait_act(1'b1);
            apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
            chk("resp flag", rdata, 32'h1);
            wait_frames();
            chk("slot mask", last_mask, 32'h1 << vec[k]);
            apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h1);
            repeat (30) @(posedge clk_sys);
            chk("quiet after rearm", {31'h0, irq_line_active}, 32'h0);
        end
        $display("test slots done");
    endtask
    task automatic t_block();
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h8000008f);
        pulse(2);
        wait_act(1'b1);
        pulse(1);
        apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
        chk("latched while blocked", rdata, 32'h6);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h4);
        wait_act(1'b0);
        wait_act(1'b1);
        chk("reassert", {31'h0, irq_line_active}, 32'h1);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h0);
        apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
        chk("zero write keeps", rdata, 32'h2);
        pulse(3);
        pulse(0);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h83);
        apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
        chk("multi clear", rdata, 32'h0);
        repeat (30) @(posedge clk_sys);
        chk("silent at zero", {31'h0, irq_line_active}, 32'h0);
        $display("test block done");
    endtask
    task automatic t_gate();
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h00000009);
        pulse(0);
        wait_frames();
        chk("gate off line", {31'h0, irq_line_active}, 32'h0);
        chk("gate off slots", last_mask, 32'h0);
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h80000009);
        apb(1'b0, `SMIRQ_OFF_CAUSE, 32'h0);
        chk("poll after unmask", rdata, 32'h1);
        wait_act(1'b1);
        chk("gate on line", {31'h0, irq_line_active}, 32'h1);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h1);
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h80000008);
        pulse(0);
        repeat (40) @(posedge clk_sys);
        chk("masked cause", {31'h0, irq_line_active}, 32'h0);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h1);
        // rising edge style: one pulse, then rest until the rearm
        apb(1'b1, `SMIRQ_OFF_ENABLE, 32'h80000011);
        pulse(0);
        wait_act(1'b1);
        chk("edge pulse", {31'h0, irq_line_active}, 32'h1);
        repeat (300) @(posedge clk_sys);
        chk("edge rest", {31'h0, irq_line_active}, 32'h0);
        chk("edge pending", {31'h0, irq_pending}, 32'h1);
        apb(1'b1, `SMIRQ_OFF_CAUSE, 32'h1);
        $display("test gate done");
    endtask
    // ----------------------------------------
    // main sequence and hang limit
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_slots();
        t_block();
        t_gate();
        finish_test();
    end
endmodule

bind smirq_top smirq_chk smirq_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ev_owner_switch(ev_owner_switch),
    .ev_response_ready(ev_response_ready), .ev_status_valid(ev_status_valid),
    .ev_accept_next_cmd(ev_accept_next_cmd), .sirq_in(sirq_in), .sirq_out(sirq_out),
    .sirq_oe(sirq_oe), .irq_pending(irq_pending), .irq_line_active(irq_line_active));
`default_nettype wire
